// [iood_decoder.sv]
// Purpose: Operand address generation and three representative file instructions,
//          with the indexed literal offset mode of the extended instruction set
// Assumes: APB slave, 20 MHz core clock, one instruction executed per INSTR write
// Notes:   Data memory is local so each instruction completes in a single cycle
`timescale 1ns/10ps
module iood_decoder
    import iood_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic             pready_out,
    output logic [31:0]      prdata_out,
    output logic             pslverr_out,
    output logic [11:0]      eff_addr_out,
    output logic             indexed_out
);

    iood_state_s state_q;
    iood_state_s state_d;

    // Data space; kept apart from the state struct to keep the copy small
    logic [7:0]  data_mem [IOOD_DEPTH];
    logic        mem_we;
    logic [11:0] mem_wa;
    logic [7:0]  mem_wd;

    // Effective address for a file argument; bit 12 flags frame-relative use
    function automatic logic [12:0] iood_resolve(input logic [7:0] farg, input logic acc,
                                                 input logic ext, input logic [3:0] bank_select_register,
                                                 input logic [11:0] fsp);
        logic [12:0] res;
        res = 13'h0000;
        if (acc) begin
            res = {1'b0, bank_select_register, farg};
        end else if (ext && (farg <= IOOD_OFFSET_MAX)) begin
            res = {1'b1, fsp + {4'h0, farg}};
        end else if (farg <= IOOD_OFFSET_MAX) begin
            res = {1'b0, IOOD_ACC_LO_BANK, farg};
        end else begin
            res = {1'b0, IOOD_ACC_HI_BANK, farg};
        end
        return res;
    endfunction : iood_resolve

    // Recognises the eight extension opcodes
    function automatic logic iood_is_ext(input logic [15:0] w);
        return (w[15:10] == IOOD_OP_EXTA) || (w[15:8] == IOOD_OP_EXTB) || (w == IOOD_OP_CALLW);
    endfunction : iood_is_ext

    // Next-state logic: bus slave, instruction execution, memory port
    always_comb begin
        logic        acc_phase;
        logic        take;
        logic [12:0] res;
        logic [7:0]  opnd;
        logic [8:0]  sum;
        logic [4:0]  half;
        logic [7:0]  bitmask;
        logic [31:0] rd;
        logic        hit;
        state_d   = state_q;
        mem_we    = 1'b0;
        mem_wa    = 12'h000;
        mem_wd    = 8'h00;
        acc_phase = psel_in && penable_in;
        take      = acc_phase && state_q.pready;
        res       = 13'h0000;
        opnd      = 8'h00;
        sum       = 9'h000;
        half      = 5'h00;
        bitmask   = 8'h00;
        rd        = 32'h0000_0000;
        hit       = 1'b1;

        // Register decode, shared by read data and error answer
        case (paddr_in)
            IOOD_OFF_CTRL: begin
                rd[IOOD_CTRL_EXT_BIT] = state_q.ext_en;
                rd[IOOD_CTRL_BSR_LSB +: 4] = state_q.bank_select_register;
            end
            IOOD_OFF_FRAME:  rd[11:0] = state_q.fsp;
            IOOD_OFF_WREG:   rd[7:0]  = state_q.wreg;
            IOOD_OFF_STATUS: rd[4:0]  = state_q.status;
            IOOD_OFF_INSTR:  rd[15:0] = state_q.instr;
            IOOD_OFF_RESULT: begin
                rd[11:0] = state_q.eff_addr;
                rd[IOOD_RES_IDX_BIT]  = state_q.indexed;
                rd[IOOD_RES_EXT_BIT]  = state_q.ext_op;
                rd[IOOD_RES_BAD_BIT]  = state_q.bad_op;
                rd[IOOD_RES_BUSY_BIT] = state_q.exec_pend;
            end
            IOOD_OFF_MADDR: rd[11:0] = state_q.mem_addr;
            IOOD_OFF_MDATA: rd[7:0]  = data_mem[state_q.mem_addr];
            default: hit = 1'b0;
        endcase

        // Answer one cycle into the access phase; pready drops after each transfer
        state_d.pready = acc_phase && !state_q.pready;
        if (acc_phase && !state_q.pready) begin
            state_d.prdata  = pwrite_in ? 32'h0000_0000 : rd;
            state_d.pslverr = !hit;
        end else begin
            state_d.pslverr = 1'b0;
        end

        // Register writes take effect only at the completing edge
        if (take && pwrite_in && hit) begin
            case (paddr_in)
                IOOD_OFF_CTRL: begin
                    state_d.ext_en = pwdata_in[IOOD_CTRL_EXT_BIT];
                    state_d.bank_select_register    = pwdata_in[IOOD_CTRL_BSR_LSB +: 4];
                end
                IOOD_OFF_FRAME:  state_d.fsp      = pwdata_in[11:0];
                IOOD_OFF_WREG:   state_d.wreg     = pwdata_in[7:0];
                IOOD_OFF_STATUS: state_d.status   = pwdata_in[4:0];
                IOOD_OFF_INSTR: begin
                    state_d.instr     = pwdata_in[15:0];
                    state_d.exec_pend = 1'b1;
                end
                IOOD_OFF_MADDR:  state_d.mem_addr = pwdata_in[11:0];
                IOOD_OFF_MDATA: begin
                    mem_we = 1'b1;
                    mem_wa = state_q.mem_addr;
                    mem_wd = pwdata_in[7:0];
                end
                default: ;
            endcase
        end

        // Execute the held instruction in one cycle; the bus cannot write again
        // until two cycles later, so the memory port never sees two writers
        if (state_q.exec_pend) begin
            state_d.exec_pend = 1'b0;
            res  = iood_resolve(state_q.instr[7:0], state_q.instr[8], state_q.ext_en,
                                state_q.bank_select_register, state_q.fsp);
            opnd = data_mem[res[11:0]];
            state_d.ext_op = iood_is_ext(state_q.instr) && state_q.ext_en;
            state_d.bad_op = iood_is_ext(state_q.instr) && !state_q.ext_en;
            state_d.eff_addr = res[11:0];
            state_d.indexed  = res[12];
            if (iood_is_ext(state_q.instr)) begin
                // Extension opcodes are only classified here, not carried out
                state_d.indexed = 1'b0;
            end else if (state_q.instr[15:10] == IOOD_OP_ADD_WORKING_TO_FILE) begin
                sum  = {1'b0, state_q.wreg} + {1'b0, opnd};
                half = {1'b0, state_q.wreg[3:0]} + {1'b0, opnd[3:0]};
                state_d.status[IOOD_ST_C]  = sum[8];
                state_d.status[IOOD_ST_DC] = half[4];
                state_d.status[IOOD_ST_Z]  = (sum[7:0] == 8'h00);
                state_d.status[IOOD_ST_OV] = (state_q.wreg[7] == opnd[7]) && (sum[7] != opnd[7]);
                state_d.status[IOOD_ST_N]  = sum[7];
                if (state_q.instr[9]) begin
                    mem_we = 1'b1;
                    mem_wa = res[11:0];
                    mem_wd = sum[7:0];
                end else begin
                    state_d.wreg = sum[7:0];
                end
            end else if (state_q.instr[15:12] == IOOD_OP_BSF) begin
                bitmask = 8'h01 << state_q.instr[11:9];
                mem_we  = 1'b1;
                mem_wa  = res[11:0];
                mem_wd  = opnd | bitmask;
            end else if (state_q.instr[15:9] == IOOD_OP_FILE_FILL_ONES) begin
                mem_we = 1'b1;
                mem_wa = res[11:0];
                mem_wd = IOOD_ALL_ONES;
            end
        end
    end

    // State register; clock enable low freezes everything
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q        <= '0;
            state_q.ext_en <= IOOD_EXT_RST;
            state_q.bank_select_register    <= IOOD_BSR_RST;
            state_q.fsp    <= IOOD_FSP_RST;
        end else if (ce_in) begin
            state_q <= state_d;
        end
    end

    // Data space write port; contents are undefined until written
    always_ff @(posedge core_clk_in) begin
        if (ce_in && mem_we) begin
            data_mem[mem_wa] <= mem_wd;
        end
    end

    // Outputs straight from the state flops
    assign pready_out   = state_q.pready;
    assign prdata_out   = state_q.prdata;
    assign pslverr_out  = state_q.pslverr;
    assign eff_addr_out = state_q.eff_addr;
    assign indexed_out  = state_q.indexed;

endmodule : iood_decoder

// [iood_pkg.sv]
// Purpose: Shared constants and state type for the indexed offset operand decoder
// Assumes: 12-bit data space, 8-bit data, APB register access with 32-bit words
// Notes:   All offsets are byte addresses of aligned 32-bit registers
package iood_pkg;

    localparam int unsigned IOOD_ADDR_W = 12;          // Data space address width
    localparam int unsigned IOOD_DEPTH  = 4096;        // Data space size in bytes

    // Register byte offsets
    localparam logic [7:0] IOOD_OFF_CTRL   = 8'h00;
    localparam logic [7:0] IOOD_OFF_FRAME  = 8'h04;
    localparam logic [7:0] IOOD_OFF_WREG   = 8'h08;
    localparam logic [7:0] IOOD_OFF_STATUS = 8'h0C;
    localparam logic [7:0] IOOD_OFF_INSTR  = 8'h10;
    localparam logic [7:0] IOOD_OFF_RESULT = 8'h14;
    localparam logic [7:0] IOOD_OFF_MADDR  = 8'h18;
    localparam logic [7:0] IOOD_OFF_MDATA  = 8'h1C;

    // Field positions
    localparam int unsigned IOOD_CTRL_EXT_BIT  = 0;    // extended_set_enable
    localparam int unsigned IOOD_CTRL_BSR_LSB  = 8;    // bank_select_register [11:8]
    localparam int unsigned IOOD_ST_C   = 0;
    localparam int unsigned IOOD_ST_DC  = 1;
    localparam int unsigned IOOD_ST_Z   = 2;
    localparam int unsigned IOOD_ST_OV  = 3;
    localparam int unsigned IOOD_ST_N   = 4;
    localparam int unsigned IOOD_RES_IDX_BIT  = 16;    // Last address was frame-relative
    localparam int unsigned IOOD_RES_EXT_BIT  = 17;    // Last word was an extension opcode while enabled
    localparam int unsigned IOOD_RES_BAD_BIT  = 18;    // Extension opcode while disabled
    localparam int unsigned IOOD_RES_BUSY_BIT = 19;    // Execution pending

    // Reset values
    localparam logic       IOOD_EXT_RST = 1'b0;
    localparam logic [3:0] IOOD_BSR_RST = 4'h0;
    localparam logic [11:0] IOOD_FSP_RST = 12'h000;

    // Addressing constants
    localparam logic [7:0] IOOD_OFFSET_MAX = 8'h5F;    // Highest file argument taken as offset
    localparam logic [3:0] IOOD_ACC_HI_BANK = 4'hF;    // Upper half of the access bank
    localparam logic [3:0] IOOD_ACC_LO_BANK = 4'h0;    // Lower half of the access bank
    localparam logic [7:0] IOOD_ALL_ONES   = 8'hFF;

    // Opcode patterns (upper bits of the instruction word; whole word for IOOD_OP_CALLW)
    localparam logic [5:0] IOOD_OP_ADD_WORKING_TO_FILE = 6'b001001;  // 0010 01da
    localparam logic [3:0] IOOD_OP_BSF   = 4'b1000;    // 1000 bbba
    localparam logic [6:0] IOOD_OP_FILE_FILL_ONES  = 7'b0110100; // 0110 100a
    localparam logic [5:0] IOOD_OP_EXTA  = 6'b111010;  // 1110 10xx group
    localparam logic [7:0] IOOD_OP_EXTB  = 8'hEB;      // 1110 1011 moves
    localparam logic [15:0] IOOD_OP_CALLW = 16'h0014;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        ext_en;
        logic [3:0]  bank_select_register;
        logic [11:0] fsp;
        logic [7:0]  wreg;
        logic [4:0]  status;
        logic [15:0] instr;
        logic        exec_pend;
        logic [11:0] eff_addr;
        logic        indexed;
        logic        ext_op;
        logic        bad_op;
        logic [11:0] mem_addr;
    } iood_state_s;

endpackage : iood_pkg

// [iood_decoder_properties.sv]
// Purpose: Port-level assertions for the indexed offset operand decoder
// Assumes: ce_in stays high while transfers run
// Notes:   Bound to iood_decoder at the foot of this file
`timescale 1ns/10ps
module iood_decoder_properties
    import iood_pkg::*;
(
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic        ce_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic        pready_out,
    input wire logic [31:0] prdata_out,
    input wire logic        pslverr_out,
    input wire logic [11:0] eff_addr_out,
    input wire logic        indexed_out
);
    logic iwr;
    logic xop;
    // Completed instruction write; execution lands on the following edge
    assign iwr = psel_in && penable_in && pwrite_in && pready_out && (paddr_in == IOOD_OFF_INSTR);
    assign xop = (pwdata_in[15:10] == IOOD_OP_EXTA);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_setup; psel_in && !penable_in; endsequence
    sequence s_req; s_setup ##1 (psel_in && penable_in); endsequence
    AST_RDY_LATE: assert property (s_req |=> pready_out)
        else $error("ready missing in second access cycle");
    AST_RDY_PULSE: assert property (pready_out && ce_in |=> !pready_out)
        else $error("ready held longer than one cycle");
    AST_ERR_MAP: assert property (pslverr_out |-> $past(paddr_in) > 8'h1C || $past(paddr_in[1:0]) != 2'h0)
        else $error("error on a mapped address");
    // Execution lands one edge after the completing edge, so outputs move two samples after iwr
    AST_HOLD: assert property (!iwr |-> ##2 ($stable(eff_addr_out) && $stable(indexed_out)))
        else $error("address changed without an instruction");
    AST_A1_BANK: assert property (iwr && pwdata_in[8] && !xop |-> ##2 (!indexed_out && eff_addr_out[7:0] == $past(pwdata_in[7:0], 2)))
        else $error("bank form address wrong");
    AST_HI_LIT: assert property (iwr && !pwdata_in[8] && pwdata_in[7:0] > IOOD_OFFSET_MAX && !xop |-> ##2 (!indexed_out && eff_addr_out == {IOOD_ACC_HI_BANK, $past(pwdata_in[7:0], 2)}))
        else $error("high argument not literal");
    AST_IDX_CAUSE: assert property (iwr ##2 indexed_out |-> $past(!pwdata_in[8] && pwdata_in[7:0] <= IOOD_OFFSET_MAX, 2))
        else $error("indexed flag without small access argument");
    AST_EXT_NOIDX: assert property (iwr && xop |-> ##2 !indexed_out)
        else $error("extension opcode marked indexed");
endmodule : iood_decoder_properties

bind iood_decoder iood_decoder_properties u_iood_decoder_properties (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .eff_addr_out(eff_addr_out), .indexed_out(indexed_out));

// [iood_decoder_bench.sv]
// Purpose: Self-checking bench for the indexed offset operand decoder
// Assumes: APB master on rising edges, clock enable held high
// Notes:   Expected values are worked out by hand from the addressing rules
`timescale 1ns/10ps
module iood_decoder_bench;
    import iood_pkg::*;
    logic        clk    = 1'b0;
    logic        rst    = 1'b1;
    logic        ce     = 1'b1;
    logic        psel   = 1'b0;
    logic        pen    = 1'b0;
    logic        pwr    = 1'b0;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pready, perr, idx, rerr;
    logic [31:0] prdata, rdat;
    logic [11:0] eff;
    int          n_fail = 0;
    int          num_checks = 0;
    // 50 ns period
    always #25 clk = ~clk;
    iood_decoder u_iood_decoder (.core_clk_in(clk), .rst_in(rst), .ce_in(ce), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
        .prdata_out(prdata), .pslverr_out(perr), .eff_addr_out(eff), .indexed_out(idx));
    task automatic report_and_stop;
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One APB transfer; request held until ready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            report_and_stop();
        end
        rdat = prdata;
        rerr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : xfer
    task automatic ex(input logic [15:0] ins);
        xfer(1'b1, IOOD_OFF_INSTR, {16'h0, ins});
    endtask : ex
    task automatic mset(input logic [11:0] a, input logic [7:0] v);
        xfer(1'b1, IOOD_OFF_MADDR, {20'h0, a});
        xfer(1'b1, IOOD_OFF_MDATA, {24'h0, v});
    endtask : mset
    task automatic mchk(input logic [11:0] a, input logic [7:0] v);
        xfer(1'b1, IOOD_OFF_MADDR, {20'h0, a});
        xfer(1'b0, IOOD_OFF_MDATA, 32'h0);
        chk("memory", rdat, {24'h0, v});
    endtask : mchk
    // Result register and ports: fl is {bad, ext, indexed}
    task automatic res(input logic [2:0] fl, input logic [11:0] e);
        xfer(1'b0, IOOD_OFF_RESULT, 32'h0);
        chk("result", {rdat[18:16], rdat[11:0]}, {17'h0, fl, e});
        chk("eff_port", {idx, eff}, {19'h0, fl[0], e});
    endtask : res
    task automatic t_reset;
        xfer(1'b0, IOOD_OFF_CTRL, 32'h0);
        chk("ctrl", rdat, 32'h0);
        xfer(1'b0, IOOD_OFF_FRAME, 32'h0);
        chk("frame", rdat, 32'h0);
    endtask : t_reset
    // Extension off: small arguments stay literal, extension opcodes flagged
    task automatic t_literal;
        ex(16'h682C);
        res(3'h0, 12'h02C);
        mchk(12'h02C, 8'hFF);
        ex(16'h6880);
        res(3'h0, 12'hF80);
        xfer(1'b1, IOOD_OFF_CTRL, 32'h0500);
        ex(16'h6910);
        res(3'h0, 12'h510);
        ex(16'hE823);
        res(3'h4, 12'h023);
    endtask : t_literal
    task automatic t_indexed;
        xfer(1'b1, IOOD_OFF_CTRL, 32'h0301);
        xfer(1'b1, IOOD_OFF_FRAME, 32'hA00);
        xfer(1'b1, IOOD_OFF_WREG, 32'h17);
        mset(12'hA2C, 8'h20);
        ex(16'h242C);
        res(3'h1, 12'hA2C);
        xfer(1'b0, IOOD_OFF_WREG, 32'h0);
        chk("wreg", rdat, 32'h37);
        ex(16'h262C);
        mchk(12'hA2C, 8'h57);
        mset(12'hA0A, 8'h55);
        ex(16'h8E0A);
        mchk(12'hA0A, 8'hD5);
        ex(16'h682C);
        mchk(12'hA2C, 8'hFF);
        ex(16'h685F);
        res(3'h1, 12'hA5F);
        ex(16'h6860);
        res(3'h0, 12'hF60);
        ex(16'h6910);
        res(3'h0, 12'h310);
        ex(16'hE823);
        res(3'h2, 12'hA23);
        xfer(1'b1, IOOD_OFF_FRAME, 32'h0);
        ex(16'h6820);
        res(3'h1, 12'h020);
    endtask : t_indexed
    // 80h + 80h gives zero with carry and overflow; later ops keep flags
    task automatic t_flags;
        xfer(1'b1, IOOD_OFF_FRAME, 32'hA00);
        xfer(1'b1, IOOD_OFF_WREG, 32'h80);
        xfer(1'b1, IOOD_OFF_STATUS, 32'h0);
        mset(12'hA40, 8'h80);
        ex(16'h2440);
        xfer(1'b0, IOOD_OFF_STATUS, 32'h0);
        chk("status_add", rdat, 32'h0D);
        ex(16'h8040);
        ex(16'h6840);
        xfer(1'b0, IOOD_OFF_STATUS, 32'h0);
        chk("status_keep", rdat, 32'h0D);
        mchk(12'hA40, 8'hFF);
    endtask : t_flags
    task automatic t_err;
        xfer(1'b0, 8'h20, 32'h0);
        chk("slverr", {31'h0, rerr}, 32'h1);
    endtask : t_err
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_literal();
        t_indexed();
        t_flags();
        t_err();
        report_and_stop();
    end
endmodule : iood_decoder_bench
